// ===== core/pipelined_sync_sram_port.sv
// write fifo and pin-level logic of the pipelined double-cycle-deselect sram
// Summary of operation
// - address captured only when a strobe is low and all selects active
// - two low address bits seed the two-bit burst counter
// - accepted strobe loads address register and burst counter seed
// - both strobes low with first select low means only the processor strobe counts
// - processor strobe ignored when first select is high
// - selected only when first low, second high, third low
// - selects sampled only on address loads, ignored on burst edges
// - single-select variant treats third select as always active
// - burst counter advances on an edge with step input low
// - global write low writes every lane regardless of lane inputs
// - lane select writes its lane only with qualifier low
// - data and parity inputs captured into a register at the edge
// - read data belongs to address captured at the previous edge
// - output enable low drives data lines, high releases them
// - first read clock after deselect keeps data lines released
// - sleep high idles the port and keeps stored contents
// - burst order strap: low linear, high interleaved, held static
// - outputs release only after the edge following a deselect
// - processor-started access ignores write and step on first edge
// - any detected write forces data lines released

////////////////////////////////////////////////////////////////////////////////
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW:0] CNT_RST  = '0;
  logic [WIDTH-1:0] cells_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;
  assign in_ready_out  = (count_q != FULL_CNT);
  assign out_valid_out = (count_q != CNT_RST);
  assign out_data_out  = cells_q[rd_ptr_q];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  always_ff @(posedge clk_in) begin
    if (push) begin
      cells_q[wr_ptr_q] <= in_data_in;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= CNT_RST;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module pipelined_sync_sram_port #(
  parameter bit SINGLE_SELECT = 1'b0
) (
  input  wire logic                              core_clk_in,
  input  wire logic                              rst_in,
  input  wire logic [sram_port_pkg::ADDR_W-1:0]  addr_in,
  input  wire logic                              processor_addr_strobe_n_in,
  input  wire logic                              controller_addr_strobe_n_in,
  input  wire logic                              burst_step_n_in,
  input  wire logic                              all_lanes_write_n_in,
  input  wire logic                              lane_write_qualifier_n_in,
  input  wire logic [sram_port_pkg::LANES-1:0]   lane_write_select_n_in,
  input  wire logic                              select_low_first_n_in,
  input  wire logic                              select_high_in,
  input  wire logic                              select_low_second_n_in,
  input  wire logic                              output_enable_n_in,
  input  wire logic                              sleep_request_in,
  input  wire logic                              burst_order_in,
  input  wire logic [sram_port_pkg::DATA_W-1:0]  dq_in,
  input  wire logic [sram_port_pkg::LANES-1:0]   lane_parity_in,
  output logic [sram_port_pkg::DATA_W-1:0]       dq_out,
  output logic [sram_port_pkg::LANES-1:0]        lane_parity_out,
  output logic                                   dq_oe_out,
  output logic                                   write_ready_out,
  output logic                                   write_dropped_out,
  output logic                                   sleeping_out
);
  import sram_port_pkg::*;

  port_state_t       st_q;
  logic [ADDR_W-1:0] base_q;
  logic [BEAT_W-1:0] beat_q;
  logic              order_q;
  logic              read_pend_q;
  logic              drive_q;
  logic              ready_q;
  logic              dropped_q;
  logic              sleeping_q;
  logic [DATA_W-1:0] rd_data_q;
  logic [LANES-1:0]  rd_par_q;

  logic              awake, sel, p_take, c_take, take, take_sel, cont, step;
  logic              wr_ctl, wr_now, rd_now, fifo_ready, head_valid, drain_ok;
  logic [LANES-1:0]  lanes;
  logic [BEAT_W-1:0] next_beat;
  logic [ADDR_W-1:0] eff_addr, cur_addr;
  logic [DATA_W-1:0] rd_data;
  logic [LANES-1:0]  rd_par;
  wr_entry_t         push_entry, head;

  function automatic logic [BEAT_W-1:0] burst_low(input logic [BEAT_W-1:0] seed,
                                                  input logic [BEAT_W-1:0] beat,
                                                  input logic linear);
    burst_low = linear ? BEAT_W'(seed + beat) : (seed ^ beat);
  endfunction

  // seed bits added to (linear) or xored with (interleaved) the counter form the low address
  function automatic logic [ADDR_W-1:0] burst_addr(input logic [ADDR_W-1:0] base,
                                                   input logic [BEAT_W-1:0] beat,
                                                   input logic linear);
    burst_addr = {base[ADDR_W-1:BEAT_W], burst_low(base[BEAT_W-1:0], beat, linear)};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // sleep blocks every strobe
  assign awake    = !sleep_request_in;
  assign sel      = !select_low_first_n_in && select_high_in &&
                    (SINGLE_SELECT || !select_low_second_n_in);
  // processor strobe gated by first select
  assign p_take   = awake && !processor_addr_strobe_n_in && !select_low_first_n_in;
  assign c_take   = awake && !controller_addr_strobe_n_in && !p_take;
  assign take     = p_take || c_take;
  // capture only with a strobe and all selects
  assign take_sel = take && sel;
  // burst edges never look at selects
  assign cont     = awake && !take && (st_q == ST_BURST);
  assign step     = cont && !burst_step_n_in;
  assign next_beat = step ? beat_q + BEAT_STEP : beat_q;
  // lane selects count only with the qualifier
  assign lanes    = !all_lanes_write_n_in ? ALL_LANES :
                    (lane_write_qualifier_n_in ? NO_LANES : ~lane_write_select_n_in);
  assign wr_ctl   = (lanes != NO_LANES);
  assign wr_now   = (c_take && sel && wr_ctl) || (cont && wr_ctl);
  assign rd_now   = (take_sel && !(c_take && wr_ctl)) || (cont && !wr_ctl);
  assign eff_addr = take ? addr_in : burst_addr(base_q, next_beat, !order_q);
  assign cur_addr = burst_addr(base_q, beat_q, !order_q);

  // input data registered into the write fifo
  assign push_entry = '{addr: eff_addr, data: dq_in, parity: lane_parity_in, mask: lanes};
  // array is single ported: drain waits for reads, yet the edge after each write can drain, so the fifo does not fill
  assign drain_ok   = awake && !read_pend_q;

  sync_fifo #(.WIDTH(ENTRY_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) wr_fifo (
    .clk_in        (core_clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (wr_now),
    .in_ready_out  (fifo_ready),
    .in_data_in    (push_entry),
    .out_valid_out (head_valid),
    .out_ready_in  (drain_ok),
    .out_data_out  (head)
  );
  //////////////////////////////////////////////////////////////////////////////
  // reads do not see writes still queued in the fifo
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [LANE_W:0] cells_q [MEM_WORDS];
    // lanes outside the mask keep their contents
    always_ff @(posedge core_clk_in) begin
      if (head_valid && drain_ok && head.mask[g]) begin
        cells_q[head.addr] <= {head.parity[g], head.data[g*LANE_W +: LANE_W]};
      end
    end
    assign rd_data[g*LANE_W +: LANE_W] = cells_q[cur_addr][LANE_W-1:0];
    assign rd_par[g]                   = cells_q[cur_addr][LANE_W];
  end
  //////////////////////////////////////////////////////////////////////////////
  // strap caught while reset is held
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      order_q <= burst_order_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        // a strobe on the waking edge counts like any other load
        ST_IDLE, ST_BURST, ST_SLEEP: begin
          if (!awake) begin
            st_q <= ST_SLEEP;
          end else if (take) begin
            st_q <= sel ? ST_BURST : ST_IDLE;
          end else if (st_q == ST_SLEEP) begin
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      base_q <= '0;
      beat_q <= BEAT_RST;
    end else if (take_sel) begin
      base_q <= addr_in;
      beat_q <= BEAT_RST;
    end else if (step) begin
      beat_q <= next_beat;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      read_pend_q <= 1'b0;
      rd_data_q   <= DATA_RST;
      rd_par_q    <= PARITY_RST;
    end else begin
      read_pend_q <= rd_now;
      if (read_pend_q) begin
        rd_data_q <= rd_data;
        rd_par_q  <= rd_par;
      end
    end
  end

  // read from deselect has no drive yet
  // drive follows the read one edge late
  // a write edge releases the lines
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= read_pend_q && !wr_now && awake;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ready_q    <= 1'b0;
      dropped_q  <= 1'b0;
      sleeping_q <= 1'b0;
    end else begin
      ready_q    <= fifo_ready;
      dropped_q  <= wr_now && !fifo_ready;
      sleeping_q <= !awake;
    end
  end

  assign dq_out            = rd_data_q;
  assign lane_parity_out   = rd_par_q;
  // asynchronous enable gates the registered drive
  assign dq_oe_out         = drive_q && !output_enable_n_in;
  assign write_ready_out   = ready_q;
  assign write_dropped_out = dropped_q;
  assign sleeping_out      = sleeping_q;

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_emerge;
    (st_q == ST_IDLE) && take_sel && !wr_now;
  endsequence
  sequence s_read_desel;
    rd_now ##1 (take && !sel && !wr_now && awake);
  endsequence

  AST_ADDR_LOAD: assert property (take_sel |=> base_q == $past(addr_in))
    else $error("address not captured on accepted strobe");
  AST_SEED_ZERO: assert property (take_sel |=> beat_q == BEAT_RST)
    else $error("burst counter not reseeded");
  AST_PROC_FIRST: assert property (p_take |-> !wr_now)
    else $error("write taken on processor load edge");
  AST_PROC_GATED: assert property ((st_q == ST_IDLE) && !processor_addr_strobe_n_in &&
      select_low_first_n_in && controller_addr_strobe_n_in |=> st_q != ST_BURST)
    else $error("processor strobe used with first select high");
  AST_DESELECT: assert property (take && !sel && awake |=> st_q == ST_IDLE)
    else $error("unselected load left port active");
  AST_BURST_HOLD: assert property (cont |=> st_q == ST_BURST)
    else $error("burst edge changed selection");
  AST_STEP: assert property (step |=> beat_q == $past(beat_q) + BEAT_STEP)
    else $error("counter did not advance");
  AST_NO_STEP: assert property (cont && burst_step_n_in |=> $stable(beat_q))
    else $error("counter moved without step");
  AST_GLOBAL: assert property (!all_lanes_write_n_in |-> lanes == ALL_LANES)
    else $error("global write missed a lane");
  AST_LANE_QUAL: assert property (lane_write_qualifier_n_in && all_lanes_write_n_in
      |-> !wr_now)
    else $error("lane write without qualifier");
  AST_PIPE: assert property (read_pend_q |=> dq_out == $past(rd_data))
    else $error("read data not from previous address");
  AST_FIRST_MASK: assert property (s_emerge |=> !drive_q)
    else $error("drive in first read clock after deselect");
  AST_DCD: assert property (s_read_desel |=> drive_q ##1 !drive_q)
    else $error("double-cycle deselect timing wrong");
  AST_WR_RELEASE: assert property (wr_now |=> !drive_q)
    else $error("lines driven on write edge");
  AST_REFUSE: assert property (take && !sel |-> !wr_now)
    else $error("write accepted while deselected");
  AST_SLEEP: assert property (sleep_request_in |=> !drive_q && !read_pend_q)
    else $error("activity during sleep");
endmodule

// ===== include/sram_port_pkg.sv
// constants, state codes and write entry layout for the pipelined sram port
package sram_port_pkg;
  localparam int ADDR_W     = 8;
  localparam int LANES      = 4;
  localparam int LANE_W     = 8;
  localparam int DATA_W     = 32;
  localparam int BEAT_W     = 2;
  localparam int MEM_WORDS  = 256;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW    = 4;

  localparam logic [BEAT_W-1:0] BEAT_RST   = 2'h0;
  localparam logic [BEAT_W-1:0] BEAT_STEP  = 2'h1;
  localparam logic [LANES-1:0]  ALL_LANES  = 4'hF;
  localparam logic [LANES-1:0]  NO_LANES   = 4'h0;
  localparam logic [DATA_W-1:0] DATA_RST   = 32'h0000_0000;
  localparam logic [LANES-1:0]  PARITY_RST = 4'h0;
  localparam logic              ORDER_RST  = 1'b1;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_BURST = 2'b01,
    ST_SLEEP = 2'b10
  } port_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0]  parity;
    logic [LANES-1:0]  mask;
  } wr_entry_t;

  localparam int ENTRY_W = $bits(wr_entry_t);
endpackage

// ===== verif/pipelined_sync_sram_port_tb_top.sv
// self-checking bench for the pipelined sram port with a word-level model
module pipelined_sync_sram_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sram_port_pkg::*;
  localparam logic [2:0] SEL_ON = 3'b010;
  localparam logic [2:0] SEL_OFF = 3'b110;
  localparam logic [4:0] NOP = 5'h1F;
  localparam logic [4:0] CWR = 5'h15;
  localparam logic [4:0] CRD = 5'h17;
  localparam logic [4:0] STEP = 5'h1B;

  logic              core_clk_in = 1'b0;
  logic              rst_in = 1'b1;
  logic              oe_n = 1'b0;
  logic              sleep_req = 1'b0;
  logic              order = 1'b0;
  logic [4:0]        ctl;
  logic [LANES-1:0]  sel_n;
  logic [2:0]        cs;
  logic [ADDR_W-1:0] addr;
  logic [35:0]       host_dq;
  logic [DATA_W-1:0] dq_o;
  logic [LANES-1:0]  par_o;
  logic              dq_oe;
  logic              wr_ready;
  logic              dropped;
  logic              sleeping;
  logic [35:0]       mem_m [MEM_WORDS];
  logic [7:0]        lfsr_q = 8'h57;
  int                errors = 0;
  int                num_checks = 0;
  wire  [35:0]       dq_wire = dq_oe ? {par_o, dq_o} : host_dq;

  always #25 core_clk_in = ~core_clk_in;

  sram_bus_model i_sram_bus_model (.clk_in(core_clk_in), .ctl_out(ctl),
    .lane_write_select_n_out(sel_n), .chip_select_out(cs), .addr_out(addr), .dq_out(host_dq));

  pipelined_sync_sram_port #(.SINGLE_SELECT(1'b0)) i_pipelined_sync_sram_port (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .addr_in(addr),
    .processor_addr_strobe_n_in(ctl[4]), .controller_addr_strobe_n_in(ctl[3]),
    .burst_step_n_in(ctl[2]), .all_lanes_write_n_in(ctl[1]), .lane_write_qualifier_n_in(ctl[0]),
    .lane_write_select_n_in(sel_n), .select_low_first_n_in(cs[2]), .select_high_in(cs[1]),
    .select_low_second_n_in(cs[0]), .output_enable_n_in(oe_n), .sleep_request_in(sleep_req),
    .burst_order_in(order), .dq_in(dq_wire[31:0]), .lane_parity_in(dq_wire[35:32]),
    .dq_out(dq_o), .lane_parity_out(par_o), .dq_oe_out(dq_oe), .write_ready_out(wr_ready),
    .write_dropped_out(dropped), .sleeping_out(sleeping));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [35:0] rnd();
    logic [35:0] v;
    v = '0;
    for (int i = 0; i < 5; i++) begin
      lfsr_q = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      v = {v[27:0], lfsr_q};
    end
    return v;
  endfunction

  function automatic logic [1:0] ba(input logic [1:0] seed, input logic [1:0] beat,
                                    input logic lin);
    return lin ? seed + beat : seed ^ beat;
  endfunction

  task automatic chk(input string name, input logic [35:0] seen, input logic [35:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // outputs seen on return come from this call's edge, which samples the previous call's inputs
  task automatic cyc(input logic [4:0] c, input logic [3:0] s, input logic [2:0] k,
                     input logic [7:0] a, input logic [35:0] d);
    i_sram_bus_model.drive(c, s, k, a, d, c[1] == 1'b0 || c[0] == 1'b0);
    // host lifts the enable on the same edge that it puts write data on the lines
    oe_n <= !(c[1] && c[0]);
    @(negedge core_clk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [4:0] c, input logic [3:0] s,
                    input logic [2:0] k, input logic [35:0] d, input logic [3:0] lanes);
    cyc(c, s, k, a, d);
    for (int g = 0; g < LANES; g++) begin
      if (lanes[g]) begin
        mem_m[a][8*g +: 8] = d[8*g +: 8];
        mem_m[a][32+g] = d[32+g];
      end
    end
  endtask

  // drain only runs once reads stop, so leave the burst first
  task automatic settle();
    cyc(CRD, 4'hF, SEL_OFF, 8'h00, 36'h0);
    repeat (20) cyc(NOP, 4'hF, SEL_OFF, 8'h00, 36'h0);
    // fifo cannot fill from the pins: the drain keeps pace with one write per edge
    chk("write ready", wr_ready, 1'b1);
    chk("write dropped", dropped, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a);
    cyc(CRD, 4'hF, SEL_OFF, 8'h00, 36'h0);
    cyc(CRD, 4'hF, SEL_ON, a, 36'h0);
    cyc(NOP, 4'hF, SEL_OFF, 8'h00, 36'h0);
    chk("first read oe", dq_oe, 1'b0);
    cyc(NOP, 4'hF, SEL_OFF, 8'h00, 36'h0);
    chk("read oe", dq_oe, 1'b1);
    chk("read data", {par_o, dq_o}, mem_m[a]);
  endtask

  task automatic do_reset(input logic o);
    @(posedge core_clk_in);
    order <= o;
    rst_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(negedge core_clk_in);
    chk("reset oe", dq_oe, 1'b0);
    chk("reset data", {par_o, dq_o}, 36'h0);
    chk("reset sleep", sleeping, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4000) @(posedge core_clk_in);
    errors++;
    final_report();
  end

  initial begin
    do_reset(1'b0);
    wr(8'h20, CWR, 4'hF, SEL_ON, rnd(), 4'hF);
    wr(8'h20, 5'h16, 4'b1010, SEL_ON, rnd(), 4'b0101);
    wr(8'h20, CRD, 4'h0, SEL_ON, rnd(), 4'h0);
    wr(8'h21, 5'h14, 4'b0111, SEL_ON, rnd(), 4'hF);
    wr(8'h30, CWR, 4'hF, SEL_ON, rnd(), 4'hF);
    wr(8'h20, CWR, 4'hF, 3'b110, rnd(), 4'h0);
    wr(8'h20, CWR, 4'hF, 3'b000, rnd(), 4'h0);
    wr(8'h20, CWR, 4'hF, 3'b011, rnd(), 4'h0);
    settle();
    rd(8'h20);
    rd(8'h21);
    $display("test lanes done");
    cyc(5'h05, 4'h0, SEL_ON, 8'h30, rnd());
    cyc(5'h0D, 4'h0, SEL_ON, 8'h31, rnd());
    wr(8'h31, 5'h1D, 4'hF, SEL_OFF, rnd(), 4'hF);
    settle();
    rd(8'h30);
    rd(8'h31);
    $display("test strobes done");
    for (int o = 0; o < 2; o++) begin
      for (int i = 0; i < 4; i++) wr(8'h40 + 8'(i), CWR, 4'hF, SEL_ON, rnd(), 4'hF);
      settle();
      do_reset(o[0]);
      for (int i = 0; i < 6; i++) begin
        if (i == 0) cyc(CRD, 4'hF, SEL_ON, 8'h41, 36'h0);
        else if (i == 2) cyc(5'h0B, 4'hF, SEL_OFF, 8'h00, 36'h0);
        else if (i < 4) cyc(STEP, 4'hF, SEL_OFF, 8'h00, 36'h0);
        else cyc(NOP, 4'hF, SEL_OFF, 8'h00, 36'h0);
        if (i >= 2) chk("burst", {par_o, dq_o}, mem_m[{6'h10, ba(2'h1, 2'(i - 2), !o[0])}]);
      end
      $display("test burst order %0d done", o);
    end
    cyc(CRD, 4'hF, SEL_OFF, 8'h00, 36'h0);
    cyc(NOP, 4'hF, SEL_OFF, 8'h00, 36'h0);
    chk("deselect hold", dq_oe, 1'b1);
    cyc(NOP, 4'hF, SEL_OFF, 8'h00, 36'h0);
    chk("deselect off", dq_oe, 1'b0);
    rd(8'h41);
    @(posedge core_clk_in);
    oe_n <= 1'b1;
    @(negedge core_clk_in);
    chk("oe high", dq_oe, 1'b0);
    @(posedge core_clk_in);
    oe_n <= 1'b0;
    wr(8'h50, CWR, 4'hF, SEL_ON, rnd(), 4'hF);
    cyc(NOP, 4'hF, SEL_OFF, 8'h00, 36'h0);
    chk("write oe", dq_oe, 1'b0);
    $display("test output enable done");
    @(posedge core_clk_in);
    sleep_req <= 1'b1;
    cyc(NOP, 4'hF, SEL_OFF, 8'h00, 36'h0);
    chk("sleeping", sleeping, 1'b1);
    cyc(CWR, 4'hF, SEL_ON, 8'h50, rnd());
    // strobes must be gone before the waking edge
    cyc(NOP, 4'hF, SEL_OFF, 8'h00, 36'h0);
    @(posedge core_clk_in);
    sleep_req <= 1'b0;
    settle();
    rd(8'h50);
    $display("test sleep done");
    final_report();
  end
endmodule

// ===== verif/sram_bus_model.sv
// processor-side pin driver for the sram port bench
module sram_bus_model (
  input  wire logic                            clk_in,
  output logic [4:0]                           ctl_out,
  output logic [sram_port_pkg::LANES-1:0]      lane_write_select_n_out,
  output logic [2:0]                           chip_select_out,
  output logic [sram_port_pkg::ADDR_W-1:0]     addr_out,
  output logic [35:0]                          dq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import sram_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // strobes and write controls start inactive, device deselected
  initial begin
    ctl_out = 5'h1F;
    lane_write_select_n_out = 4'hF;
    chip_select_out = 3'b110;
    addr_out = 8'h00;
    dq_out = 36'h0_0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // ctl is {proc strobe, ctrl strobe, step, global write, qualifier}, all active low
  task automatic drive(input logic [4:0] ctl, input logic [3:0] sel_n, input logic [2:0] cs,
                       input logic [7:0] a, input logic [35:0] d, input bit wr);
    @(posedge clk_in);
    ctl_out <= ctl;
    lane_write_select_n_out <= sel_n;
    chip_select_out <= cs;
    addr_out <= a;
    // released bus flips, so stale data never looks valid
    dq_out <= wr ? d : ~dq_out;
  endtask
endmodule
